// ===== pkg/smam_defines.vh
`ifndef SMAM_DEFINES_VH
`define SMAM_DEFINES_VH
// processor addresses
`define SMAM_ADR_SUBDATA   8'h7a
`define SMAM_ADR_SUBSEL    8'h7b
`define SMAM_ADR_SHARED    8'hfa
`define SMAM_ADR_CLAIM     8'hfb
// subaddress select field in 7b data
`define SMAM_SEL_LSB       4
`define SMAM_SEL_MSB       6
`define SMAM_SEL_TO_VERT   3'h6
// subaddresses
`define SMAM_SUB_ADR_LO    3'h0
`define SMAM_SUB_ADR_HI    3'h1
`define SMAM_SUB_HANDOFF   3'h5
`define SMAM_SUB_HI_RW_SEL 3'h1
`define SMAM_HANDOFF_BITS  2'h3
// bit of 7a.1 that selects memory write
`define SMAM_HI_RW_BIT     2
// reset values
`define SMAM_RST_ADDR      10'h000
`define SMAM_RST_SUB       3'h0
`define SMAM_RST_BYTE      8'h00
// counts
`define SMAM_MEM_LAST      10'h3e7
`define SMAM_DSP_LAST      9'h1f3
`define SMAM_MARK_LAST     4'hf
`define SMAM_FIFO_DEPTH    8
`define SMAM_FIFO_AW       3
`endif

// ===== logic/smam_marker.v
`timescale 1ns/100ps
`include "smam_defines.vh"

module smam_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `SMAM_FIFO_DEPTH,
  parameter AW    = `SMAM_FIFO_AW
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             nrst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  reg [AW:0]      cnt_d;
  reg             rdy_q;
  wire            push;
  wire            pop;

  assign in_ready  = rdy_q;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @* begin
    cnt_d = cnt_q;
    if (push & !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rdy_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != DEPTH[AW:0]);
    end
  end
endmodule // smam_fifo

// Summary of operation
// - while grant is low this block drives the ten display address lines
// - each address step pulse advances the presented address by one, wrapping from 999 back to 0; a same-cycle write to 7a.0 or 7a.1 wins over the step
// - loaded 10-bit address reaches memory only during grant; read/write output is driven at all times
// - 7a, 7b, fa are shared by both boards; fb is horizontal only
// - strobe forwarded to vertical board only while it owns access, else low
// - 7a splits into eight subaddresses chosen by three bits written to 7b
// - any read of fb gives access to the horizontal board
// - writing 110 in bits 6..4 to 7b hands access to the vertical board
// - writing 11 in bits 6..5 to 7a.5 hands access to vertical board
// - display point strobe latches address lines into the converter holding latch
// - update intensity starts a marker pulse sixteen display strobes long
// - marker pulse rising edge raises point hold, freezing the display counter
// - cursor occurs at each of 500 positions, advancing one per sweep
// - retrace blank flip-flop driven by address msb and display strobe
// - memory holds 1000 points, addressed by buffers or horizontal logic
// - up and down comparator outputs steer the 10-bit tracking counter
// - request high is taken by pulling it low while sync low; then grant
// - msb falling with cursor low sets blank for one display period
module smam_marker (
  // clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  // processor bus
  input  wire [7:0] cpu_addr,
  input  wire [7:0] cpu_wdata,
  input  wire       cpu_read,
  input  wire       processor_strobe,
  output reg  [7:0] cpu_rdata,
  output reg        forwarded_vertical_strobe,
  output wire       cpu_wr_ready,
  // memory handshake
  input  wire       bus_req_in,
  input  wire       sync_in,
  output reg        bus_req_out,
  output reg        bus_req_oe,
  input  wire       mem_grant_n,
  input  wire       address_step_pulse,
  // memory address and data
  input  wire [9:0] display_address_lines_in,
  output reg  [9:0] display_address_lines_out,
  output reg        display_address_oe,
  output reg        mem_rw_out,
  output reg  [7:0] mem_wdata,
  output reg        mem_wr,
  // display timing
  input  wire       display_point_strobe,
  input  wire       update_intensity,
  input  wire       cursor_line,
  output reg  [9:0] hold_level,
  output reg        marker_pulse,
  output reg        point_hold,
  output reg  [8:0] display_count,
  output reg        retrace_blank,
  // tracking sweep loop
  input  wire       sweep_up,
  input  wire       sweep_down,
  output reg  [9:0] sweep_count
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PULL = 3'b010;
  localparam ST_GRNT = 3'b100;

  reg [2:0] req_st_q;
  reg       vert_q;
  reg [2:0] sub_q;
  reg [7:0] sub_reg_q [0:7];
  reg [9:0] addr_q;
  reg       rw_q;
  reg [3:0] mark_cnt_q;
  reg       upd_q;
  reg       hd9_q;
  reg       wr_done_q;
  wire      is_7a;
  wire      is_7b;
  wire      is_fa;
  wire      is_fb;
  wire      shared;
  wire      hwr;
  wire      hrd;
  wire      f_valid;
  wire      f_ready;
  wire [7:0] f_data;
  wire [2:0] sel_bits;
  integer   i;

  assign is_7a    = (cpu_addr == `SMAM_ADR_SUBDATA);
  assign is_7b    = (cpu_addr == `SMAM_ADR_SUBSEL);
  assign is_fa    = (cpu_addr == `SMAM_ADR_SHARED);
  assign is_fb    = (cpu_addr == `SMAM_ADR_CLAIM);
  assign shared   = is_7a | is_7b | is_fa;
  assign hwr      = processor_strobe & !cpu_read & !vert_q;
  assign hrd      = processor_strobe & cpu_read & !vert_q;
  assign sel_bits = cpu_wdata[`SMAM_SEL_MSB:`SMAM_SEL_LSB];
  assign f_ready  = !mem_grant_n & rw_q & !wr_done_q;

  smam_fifo #(
    .WIDTH (8),
    .DEPTH (`SMAM_FIFO_DEPTH),
    .AW    (`SMAM_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (hwr & is_fa),
    .in_ready  (cpu_wr_ready),
    .in_data   (cpu_wdata),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // access ownership, subaddress select and registers
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vert_q <= 1'b0;
      sub_q  <= `SMAM_RST_SUB;
      rw_q   <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        sub_reg_q[i] <= `SMAM_RST_BYTE;
      end
    end else begin
      if (processor_strobe & cpu_read & is_fb) begin
        vert_q <= 1'b0;
      end else if (hwr & is_7b) begin
        sub_q <= sel_bits;
        if (sel_bits == `SMAM_SEL_TO_VERT) begin
          vert_q <= 1'b1;
        end
      end else if (hwr & is_7a) begin
        sub_reg_q[sub_q] <= cpu_wdata;
        if (sub_q == `SMAM_SUB_HI_RW_SEL) begin
          rw_q <= cpu_wdata[`SMAM_HI_RW_BIT];
        end
        if (sub_q == `SMAM_SUB_HANDOFF && cpu_wdata[6:5] == `SMAM_HANDOFF_BITS) begin
          vert_q <= 1'b1;
        end
      end
    end
  end

  // processor-loaded address counter
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= `SMAM_RST_ADDR;
    end else if (hwr & is_7a & (sub_q == `SMAM_SUB_ADR_LO)) begin
      addr_q <= {addr_q[9:8], cpu_wdata};
    end else if (hwr & is_7a & (sub_q == `SMAM_SUB_ADR_HI)) begin
      addr_q <= {cpu_wdata[1:0], addr_q[7:0]};
    end else if (address_step_pulse) begin
      if (addr_q == `SMAM_MEM_LAST) begin
        addr_q <= `SMAM_RST_ADDR;
      end else begin
        addr_q <= addr_q + 10'h001;
      end
    end
  end

  // strobe steering, read data, address drive
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      forwarded_vertical_strobe <= 1'b0;
      cpu_rdata                 <= `SMAM_RST_BYTE;
      display_address_lines_out <= `SMAM_RST_ADDR;
      display_address_oe        <= 1'b0;
      mem_rw_out                <= 1'b0;
    end else begin
      forwarded_vertical_strobe <= processor_strobe & vert_q & shared;
      if (hrd) begin
        if (is_7a) begin
          cpu_rdata <= sub_reg_q[sub_q];
        end else if (is_7b) begin
          cpu_rdata <= {1'b0, sub_q, 4'h0};
        end else if (is_fa) begin
          cpu_rdata <= {6'h00, f_valid, cpu_wr_ready};
        end else if (is_fb) begin
          cpu_rdata <= {6'h00, rw_q, vert_q};
        end else begin
          cpu_rdata <= `SMAM_RST_BYTE;
        end
      end
      display_address_lines_out <= addr_q;
      display_address_oe        <= !mem_grant_n;
      mem_rw_out                <= rw_q;
    end
  end

  // memory request handshake
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_st_q    <= ST_IDLE;
      bus_req_out <= 1'b0;
      bus_req_oe  <= 1'b0;
    end else begin
      bus_req_out <= 1'b0;
      case (req_st_q)
        ST_IDLE: begin
          if (bus_req_in & !sync_in) begin
            req_st_q   <= ST_PULL;
            bus_req_oe <= 1'b1;
          end
        end
        ST_PULL: begin
          if (!mem_grant_n) begin
            req_st_q <= ST_GRNT;
          end
        end
        ST_GRNT: begin
          if (mem_grant_n) begin
            req_st_q   <= ST_IDLE;
            bus_req_oe <= 1'b0;
          end
        end
        default: begin
          req_st_q   <= ST_IDLE;
          bus_req_oe <= 1'b0;
        end
      endcase
    end
  end

  // buffered write data, one word per grant
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_wdata <= `SMAM_RST_BYTE;
      mem_wr    <= 1'b0;
      wr_done_q <= 1'b0;
    end else begin
      mem_wr <= f_valid & f_ready;
      if (f_valid & f_ready) begin
        mem_wdata <= f_data;
        wr_done_q <= 1'b1;
      end else if (mem_grant_n) begin
        wr_done_q <= 1'b0;
      end
    end
  end

  // update marker, point hold, display counter, blanking
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_level    <= `SMAM_RST_ADDR;
      marker_pulse  <= 1'b0;
      point_hold    <= 1'b0;
      mark_cnt_q    <= 4'h0;
      upd_q         <= 1'b0;
      hd9_q         <= 1'b0;
      display_count <= 9'h000;
      retrace_blank <= 1'b0;
    end else begin
      upd_q <= update_intensity;
      if (update_intensity & !upd_q & !marker_pulse) begin
        marker_pulse <= 1'b1;
        point_hold   <= 1'b1;
        mark_cnt_q   <= 4'h0;
      end else if (display_point_strobe & marker_pulse) begin
        if (mark_cnt_q == `SMAM_MARK_LAST) begin
          marker_pulse <= 1'b0;
          point_hold   <= 1'b0;
        end else begin
          mark_cnt_q <= mark_cnt_q + 4'h1;
        end
      end
      if (display_point_strobe) begin
        hold_level <= display_address_lines_in;
        hd9_q      <= display_address_lines_in[9];
        retrace_blank <= hd9_q & !display_address_lines_in[9] & !cursor_line;
        if (!point_hold) begin
          if (display_count == `SMAM_DSP_LAST) begin
            display_count <= 9'h000;
          end else begin
            display_count <= display_count + 9'h001;
          end
        end
      end
    end
  end

  // tracking sweep counter
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sweep_count <= `SMAM_RST_ADDR;
    end else if (sweep_up & !sweep_down & (sweep_count != 10'h3ff)) begin
      sweep_count <= sweep_count + 10'h001;
    end else if (sweep_down & !sweep_up & (sweep_count != 10'h000)) begin
      sweep_count <= sweep_count - 10'h001;
    end
  end
endmodule // smam_marker

// ===== tb/smam_marker_sva.sv
`timescale 1ns/100ps
module smam_marker_sva (
  // clock and reset
  input wire       core_clk,
  input wire       nrst,
  // observed ports
  input wire       processor_strobe,
  input wire       forwarded_vertical_strobe,
  input wire       mem_grant_n,
  input wire       display_address_oe,
  input wire       address_step_pulse,
  input wire [9:0] display_address_lines_out,
  input wire [9:0] display_address_lines_in,
  input wire       display_point_strobe,
  input wire       cursor_line,
  input wire       retrace_blank,
  input wire [9:0] hold_level,
  input wire       marker_pulse,
  input wire       point_hold,
  input wire [8:0] display_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  fwd_gate_a: assert property (forwarded_vertical_strobe |-> $past(processor_strobe))
    else $error("forwarded strobe without processor strobe");
  grant_drive_a: assert property ($fell(mem_grant_n) |=> display_address_oe)
    else $error("address lines not driven in grant");
  grant_free_a: assert property ($rose(mem_grant_n) |=> !display_address_oe)
    else $error("address lines held after grant");
  step_add_a: assert property (address_step_pulse && !processor_strobe |-> ##2
    display_address_lines_out == $past(display_address_lines_out) + 10'h001)
    else $error("address step did not add one");
  hold_latch_a: assert property (display_point_strobe |=> hold_level == $past(display_address_lines_in))
    else $error("holding latch missed address");
  blank_cause_a: assert property ($rose(retrace_blank) |-> $past(display_point_strobe)
    && !$past(cursor_line) && !$past(display_address_lines_in[9]))
    else $error("blank without msb fall");
  blank_one_a: assert property (retrace_blank && display_point_strobe |=> !retrace_blank)
    else $error("blank longer than one period");
  marker_hold_a: assert property ($rose(marker_pulse) |-> $rose(point_hold))
    else $error("point hold not raised with marker");
  count_freeze_a: assert property (display_point_strobe && point_hold |=> $stable(display_count))
    else $error("display counter moved in hold");
  cover property ($rose(retrace_blank));
  cover property (forwarded_vertical_strobe);
  cover property ($fell(mem_grant_n));
endmodule // smam_marker_sva

bind smam_marker smam_marker_sva u_sva (
  .core_clk(core_clk), .nrst(nrst), .processor_strobe(processor_strobe),
  .forwarded_vertical_strobe(forwarded_vertical_strobe), .mem_grant_n(mem_grant_n),
  .display_address_oe(display_address_oe), .address_step_pulse(address_step_pulse),
  .display_address_lines_out(display_address_lines_out), .display_address_lines_in(display_address_lines_in),
  .display_point_strobe(display_point_strobe), .cursor_line(cursor_line), .retrace_blank(retrace_blank),
  .hold_level(hold_level), .marker_pulse(marker_pulse), .point_hold(point_hold), .display_count(display_count)
);

// ===== tb/smam_vert_model.sv
`timescale 1ns/100ps
module smam_vert_model (
  // clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  // handshake
  input  wire       sync_in,
  input  wire       bus_req_oe,
  input  wire       bus_req_out,
  input  wire       want,
  output wire       bus_req_in,
  output reg        mem_grant_n,
  output reg        address_step_pulse
);
  reg [2:0] cnt_q;
  // pulled line shows the driven level, else our own drive
  assign bus_req_in = bus_req_oe ? bus_req_out : want;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_grant_n <= 1'b1;
      address_step_pulse <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      address_step_pulse <= 1'b0;
      if (cnt_q == 3'h0) begin
        if (want && !bus_req_in && !sync_in) begin
          mem_grant_n <= 1'b0;
          cnt_q <= 3'h4;
        end
      end else if (cnt_q == 3'h7) begin
        if (!bus_req_oe)
          cnt_q <= 3'h0;
      end else begin
        address_step_pulse <= ~cnt_q[0];
        if (cnt_q == 3'h1) begin
          mem_grant_n <= 1'b1;
          cnt_q <= 3'h7;
        end else
          cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule // smam_vert_model

// ===== tb/smam_marker_test.sv
`timescale 1ns/100ps
`include "smam_defines.vh"
module smam_marker_test;
  reg        core_clk, nrst, cpu_read, strobe, want, sync_in, dps, upd, curs, sw_up, sw_dn, seen, done, fv_q;
  reg  [7:0] cpu_addr, cpu_wdata, rd_q, wd_q;
  reg  [9:0] hz_addr, adr_q, dc_q;
  wire [7:0] cpu_rdata, mem_wdata;
  wire [9:0] lines_out, hold_level, sweep_count, lines;
  wire [8:0] display_count;
  wire       fvs, wr_rdy, req_oe, grant_n, step, lines_oe, rw, mem_wr, marker, phold, blank, req, req_out;
  integer    n_mismatch, n_tests, i, k, nw;
  assign lines = lines_oe ? lines_out : hz_addr;
  smam_marker DUT (
    .core_clk(core_clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_read(cpu_read),
    .processor_strobe(strobe), .cpu_rdata(cpu_rdata), .forwarded_vertical_strobe(fvs),
    .cpu_wr_ready(wr_rdy), .bus_req_in(req), .sync_in(sync_in), .bus_req_out(req_out), .bus_req_oe(req_oe),
    .mem_grant_n(grant_n), .address_step_pulse(step), .display_address_lines_in(lines),
    .display_address_lines_out(lines_out), .display_address_oe(lines_oe), .mem_rw_out(rw),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .display_point_strobe(dps), .update_intensity(upd),
    .cursor_line(curs), .hold_level(hold_level), .marker_pulse(marker), .point_hold(phold),
    .display_count(display_count), .retrace_blank(blank), .sweep_up(sw_up), .sweep_down(sw_dn),
    .sweep_count(sweep_count));
  smam_vert_model u_vert (.core_clk(core_clk), .nrst(nrst), .sync_in(sync_in), .bus_req_oe(req_oe),
    .bus_req_out(req_out),
    .want(want), .bus_req_in(req), .mem_grant_n(grant_n), .address_step_pulse(step));
  task print_verdict;
    begin
      $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [9:0] got, input [9:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acc(input r, input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk);
      cpu_read = r;
      cpu_addr = a;
      cpu_wdata = d;
      strobe = 1;
      @(negedge core_clk);
      strobe = 0;
      rd_q = cpu_rdata;
      fv_q = fvs;
    end
  endtask
  task dstb(input [9:0] a, input c);
    begin
      @(negedge core_clk);
      hz_addr = a;
      curs = c;
      dps = 1;
      @(negedge core_clk);
      dps = 0;
    end
  endtask
  task grant;
    begin
      want = 1;
      nw = 0;
      seen = 0;
      done = 0;
      for (i = 0; i < 40 && !done; i = i + 1) begin
        @(negedge core_clk);
        if (lines_oe && !seen) begin
          seen = 1;
          adr_q = lines_out;
          want = 0;
        end
        if (mem_wr) begin
          nw = nw + 1;
          wd_q = mem_wdata;
        end
        if (seen && !lines_oe && !req_oe)
          done = 1;
      end
      if (!done) begin
        n_mismatch = n_mismatch + 1;
        print_verdict;
      end
    end
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {nrst, cpu_read, strobe, want, sync_in, dps, upd, curs, sw_up, sw_dn} = 10'h000;
    {cpu_addr, cpu_wdata, hz_addr} = 26'h000_0000;
    repeat (2) @(negedge core_clk);
    nrst = 1;
    chk(wr_rdy, 1);
    chk(lines_oe, 0);
    acc(1, 8'h10, 8'h00);
    chk(rd_q, 0);
    acc(0, `SMAM_ADR_SUBSEL, 8'h00);
    acc(0, `SMAM_ADR_SUBDATA, 8'h34);
    acc(0, `SMAM_ADR_SUBSEL, 8'h10);
    acc(0, `SMAM_ADR_SUBDATA, 8'h02);
    acc(1, `SMAM_ADR_SUBDATA, 8'h00);
    chk(rd_q, 8'h02);
    acc(1, `SMAM_ADR_SUBSEL, 8'h00);
    chk(rd_q, 8'h10);
    sync_in = 1;
    want = 1;
    repeat (3) @(negedge core_clk);
    chk(req_oe, 0);
    sync_in = 0;
    grant;
    chk(adr_q, 10'h234);
    chk(lines_out, 10'h236);
    chk(nw[9:0], 0);
    acc(0, `SMAM_ADR_SUBDATA, 8'h06);
    @(negedge core_clk);
    chk(rw, 1);
    for (k = 0; k < 9; k = k + 1)
      acc(0, `SMAM_ADR_SHARED, k[7:0]);
    chk(wr_rdy, 0);
    for (k = 0; k < 8; k = k + 1) begin
      grant;
      chk(nw[9:0], 1);
      chk(wd_q, k[9:0]);
    end
    chk(wr_rdy, 1);
    acc(0, `SMAM_ADR_SUBSEL, 8'h60);
    chk(fv_q, 0);
    acc(0, `SMAM_ADR_SUBDATA, 8'h00);
    chk(fv_q, 1);
    acc(0, `SMAM_ADR_SHARED, 8'h00);
    chk(fv_q, 1);
    acc(1, `SMAM_ADR_CLAIM, 8'h00);
    acc(0, `SMAM_ADR_SUBDATA, 8'h00);
    chk(fv_q, 0);
    acc(0, `SMAM_ADR_SUBSEL, 8'h50);
    acc(0, `SMAM_ADR_SUBDATA, 8'h40);
    acc(0, `SMAM_ADR_SUBDATA, 8'h60);
    chk(fv_q, 0);
    acc(0, `SMAM_ADR_SUBDATA, 8'h00);
    chk(fv_q, 1);
    acc(1, `SMAM_ADR_CLAIM, 8'h00);
    for (k = 0; k < 2; k = k + 1) begin
      dstb(10'h200, 0);
      chk(hold_level, 10'h200);
      dstb(10'h000, k[0]);
      chk(blank, !k);
      dstb(10'h000, 0);
      chk(blank, 0);
    end
    dc_q = display_count;
    @(negedge core_clk);
    upd = 1;
    repeat (2) @(negedge core_clk);
    chk(phold, 1);
    for (nw = 0; nw < 40 && marker; nw = nw + 1)
      dstb(10'h100, 0);
    upd = 0;
    chk(nw[9:0], 16);
    chk(display_count, dc_q);
    dstb(10'h100, 0);
    chk(display_count, dc_q + 10'h001);
    sw_up = 1;
    repeat (5) @(negedge core_clk);
    sw_up = 0;
    chk(sweep_count, 10'h005);
    sw_dn = 1;
    repeat (2) @(negedge core_clk);
    sw_dn = 0;
    chk(sweep_count, 10'h003);
    print_verdict;
  end
endmodule // smam_marker_test
